/* adrr_readout.sv */
// readout register block: status, results and sample queue behind the link
//
// Contract
// - read-only revision code register, eight bits
// - status bit 4 mirrors nonvolatile controller busy
// - status bit 3 sets on detected activity
// - overrun sets bit 2, oldest sample dropped
// - bit 1 set when fill reaches watermark
// - bit 0 set on complete xyz set
// - fill count in low seven bits
// - temperature split high nibble, low byte
// - temperature not double buffered, host tolerates tearing
// - axis twenty bits left justified, three bytes
// - queue entry three bytes, most significant first
// - queue read pops entry, host finishes three
// - sustained queue reading pops every third byte
// - burst at queue address keeps pointer fixed
// - queue reached by increment returns zero, no pop
`timescale 1ns/1ps
module adrr_readout #(
  parameter logic [7:0] REV_CODE    = 8'h5A,  // arbitrary revision value
  parameter int         QUEUE_DEPTH = adrr_pkg::QUEUE_MAX
) (
  // core clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst,
  // measurement results from the signal chain
  input  wire logic                            measValid,
  input  wire logic [adrr_pkg::AXIS_W-1:0]     accelXResult,
  input  wire logic [adrr_pkg::AXIS_W-1:0]     accelYResult,
  input  wire logic [adrr_pkg::AXIS_W-1:0]     accelZResult,
  input  wire logic [adrr_pkg::TEMP_W-1:0]     temperature,
  // queue samples from the signal chain
  input  wire logic                            sampleValid,
  input  wire logic [adrr_pkg::ENTRY_W-1:0]    sampleWord,
  // status sources and configuration
  input  wire logic                            activityDetect,
  input  wire logic                            nonvolatileBusyFlag,
  input  wire logic [adrr_pkg::FILL_W-1:0]     watermarkLevel,
  // link side, clocked by the serial interface
  input  wire logic                            linkClk,
  input  wire logic                            linkStart,
  input  wire logic [adrr_pkg::ADDR_W-1:0]     linkAddr,
  input  wire logic                            linkRead,
  output logic [adrr_pkg::BYTE_W-1:0]          linkData,
  output logic                                 linkDataValid,
  output logic                                 linkBusy
);

  localparam int LVL_W = $clog2(QUEUE_DEPTH + 1);

  // ---------------- link domain ----------------

  logic                          linkRstSync1_r;   // reset crossing, first stage
  logic                          linkRstSync2_r;   // reset usable in link domain
  logic                          reqTog_r;         // flips once per request
  logic                          reqIsRead_r;      // held request kind
  logic [adrr_pkg::ADDR_W-1:0]   reqAddr_r;        // held start address
  logic                          ackSync1_r;       // ack crossing, first stage
  logic                          ackSync2_r;       // ack crossing, second stage
  logic                          ackSeen_r;        // last ack consumed
  logic [adrr_pkg::BYTE_W-1:0]   linkData_r;       // returned byte
  logic                          linkDataValid_r;  // one-cycle byte strobe
  logic                          linkBusy_r;       // request in flight
  logic                          linkAccept;       // new request taken
  logic                          ackArrived;       // answer from core

  // core domain signals read by the link side
  logic                          ackTog_r;         // flips once per answer
  logic [adrr_pkg::BYTE_W-1:0]   rdData_r;         // byte held for the link

  assign linkAccept = ~linkBusy_r & (linkStart | linkRead);
  assign ackArrived = (ackSync2_r != ackSeen_r);
  assign linkData      = linkData_r;
  assign linkDataValid = linkDataValid_r;
  assign linkBusy      = linkBusy_r;

  // bring core reset over to the link clock
  always_ff @(posedge linkClk)
  begin
    linkRstSync1_r <= rst;
    linkRstSync2_r <= linkRstSync1_r;
  end

  // answer toggle synchroniser
  always_ff @(posedge linkClk)
  begin
    if (linkRstSync2_r)
    begin
      ackSync1_r <= 1'b0;
      ackSync2_r <= 1'b0;
    end
    else
    begin
      ackSync1_r <= ackTog_r;
      ackSync2_r <= ackSync1_r;
    end
  end

  // request capture: held steady until the answer returns
  always_ff @(posedge linkClk)
  begin
    if (linkRstSync2_r)
    begin
      reqTog_r    <= 1'b0;
      reqIsRead_r <= 1'b0;
      reqAddr_r   <= '0;
      linkBusy_r  <= 1'b0;
    end
    else if (linkAccept)
    begin
      reqTog_r    <= ~reqTog_r;
      reqIsRead_r <= ~linkStart;        // start takes priority over read
      reqAddr_r   <= linkAddr;
      linkBusy_r  <= 1'b1;
    end
    else if (ackArrived)
      linkBusy_r <= 1'b0;
  end

  // answer capture toward the serial shifter
  always_ff @(posedge linkClk)
  begin
    if (linkRstSync2_r)
    begin
      ackSeen_r       <= 1'b0;
      linkData_r      <= adrr_pkg::BYTE_ZERO;
      linkDataValid_r <= 1'b0;
    end
    else
    begin
      ackSeen_r       <= ackSync2_r;
      linkDataValid_r <= ackArrived & reqIsRead_r;
      if (ackArrived & reqIsRead_r)
        linkData_r <= rdData_r;
    end
  end

  // ---------------- core domain ----------------

  logic                          reqSync1_r;      // request crossing, first stage
  logic                          reqSync2_r;      // request crossing, second stage
  logic                          reqSeen_r;       // last request handled
  logic [adrr_pkg::ADDR_W-1:0]   ptr_r;           // register address pointer
  logic                          queueDirect_r;   // burst began at queue address
  logic [1:0]                    byteIdx_r;       // byte position within entry
  logic [adrr_pkg::ENTRY_W-1:0]  entry_r;         // entry being transferred
  logic [adrr_pkg::AXIS_W-1:0]   accelX_r;        // latest x result
  logic [adrr_pkg::AXIS_W-1:0]   accelY_r;        // latest y result
  logic [adrr_pkg::AXIS_W-1:0]   accelZ_r;        // latest z result
  logic                          dataReady_r;     // sticky complete set
  logic                          activity_r;      // sticky activity
  logic                          overrun_r;       // sticky overrun
  logic                          watermark_r;     // fill at or above level

  // core decode wires
  logic                          reqNew;          // request waiting
  logic                          doStart;         // load pointer
  logic                          doRead;          // return one byte
  logic                          ptrAtQueue;      // pointer on queue port
  logic                          queueRead;       // popping-style read
  logic                          hostPop;         // entry leaves queue for host
  logic                          dropOld;         // entry discarded on overrun
  logic                          clrStatus;       // status register read
  logic                          ptrHold;         // pointer stays put
  logic [7:0]                    statusByte;      // assembled status
  logic [7:0]                    regByte;         // selected plain register
  logic [7:0]                    queueByte;       // selected queue byte
  logic [7:0]                    readByte;        // byte to answer with

  // queue wires
  logic                          fifoOutValid;
  logic [adrr_pkg::ENTRY_W-1:0]  fifoOutData;
  logic [LVL_W-1:0]              fifoLevel;
  logic                          fifoFull;
  logic [adrr_pkg::FILL_W-1:0]   fillCount;

  // request toggle synchroniser
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reqSync1_r <= 1'b0;
      reqSync2_r <= 1'b0;
    end
    else
    begin
      reqSync1_r <= reqTog_r;
      reqSync2_r <= reqSync1_r;
    end
  end

  // request decode; held link fields are stable while a request waits
  assign reqNew     = (reqSync2_r != reqSeen_r);
  assign doStart    = reqNew & ~reqIsRead_r;
  assign doRead     = reqNew & reqIsRead_r;
  assign ptrAtQueue = (ptr_r == adrr_pkg::REG_QUEUE);
  assign queueRead  = doRead & ptrAtQueue & queueDirect_r;
  assign hostPop    = queueRead & (byteIdx_r == 2'h0) & fifoOutValid;
  assign ptrHold    = ptrAtQueue & queueDirect_r;
  assign clrStatus  = doRead & (ptr_r == adrr_pkg::REG_STATUS);

  // overrun: a sample arriving at a full queue pushes out the oldest
  assign dropOld    = sampleValid & fifoFull & ~hostPop;
  assign fillCount  = adrr_pkg::FILL_W'(fifoLevel);

  // status byte, reserved bits zero
  assign statusByte = {3'h0, nonvolatileBusyFlag, activity_r,
                       overrun_r, watermark_r, dataReady_r};

  // queue byte: first byte comes straight off the head
  assign queueByte =
      ~queueDirect_r ? adrr_pkg::BYTE_ZERO :
      (byteIdx_r == 2'h0) ? (fifoOutValid ? fifoOutData[23:16] : adrr_pkg::BYTE_ZERO) :
      (byteIdx_r == 2'h1) ? entry_r[15:8] : entry_r[7:0];

  assign readByte = ptrAtQueue ? queueByte : regByte;

  // plain register selection
  always_comb
  begin
    unique case (ptr_r)
      adrr_pkg::REG_REVISION:  regByte = REV_CODE;
      adrr_pkg::REG_STATUS:    regByte = statusByte;
      adrr_pkg::REG_FILL:      regByte = {1'b0, fillCount};
      adrr_pkg::REG_TEMP_HIGH: regByte = {4'h0, temperature[11:8]};
      adrr_pkg::REG_TEMP_LOW:  regByte = temperature[7:0];
      adrr_pkg::REG_X_UPPER:   regByte = accelX_r[19:12];
      adrr_pkg::REG_X_MIDDLE:  regByte = accelX_r[11:4];
      adrr_pkg::REG_X_LOWER:   regByte = {accelX_r[3:0], 4'h0};
      adrr_pkg::REG_Y_UPPER:   regByte = accelY_r[19:12];
      adrr_pkg::REG_Y_MIDDLE:  regByte = accelY_r[11:4];
      adrr_pkg::REG_Y_LOWER:   regByte = {accelY_r[3:0], 4'h0};
      adrr_pkg::REG_Z_UPPER:   regByte = accelZ_r[19:12];
      adrr_pkg::REG_Z_MIDDLE:  regByte = accelZ_r[11:4];
      adrr_pkg::REG_Z_LOWER:   regByte = {accelZ_r[3:0], 4'h0};
      default:                 regByte = adrr_pkg::BYTE_ZERO;          // unmapped reads zero
    endcase
  end

  // pointer and burst mode
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ptr_r         <= '0;
      queueDirect_r <= 1'b0;
    end
    else if (doStart)
    begin
      ptr_r         <= reqAddr_r;
      queueDirect_r <= (reqAddr_r == adrr_pkg::REG_QUEUE);
    end
    else if (doRead & ~ptrHold)
    begin
      ptr_r         <= ptr_r + 8'h01;
      queueDirect_r <= 1'b0;
    end
  end

  // entry byte position persists across frames so single reads finish it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      byteIdx_r <= 2'h0;
      entry_r   <= adrr_pkg::ENTRY_RESET;
    end
    else if (queueRead)
    begin
      if (byteIdx_r == 2'h0)
      begin
        // empty queue: answer zero and stay on the first byte
        entry_r   <= fifoOutValid ? fifoOutData : adrr_pkg::ENTRY_RESET;
        byteIdx_r <= fifoOutValid ? 2'h1 : 2'h0;
      end
      else
        byteIdx_r <= (byteIdx_r == adrr_pkg::LAST_BYTE) ? 2'h0 : byteIdx_r + 2'h1;
    end
  end

  // answer hand-back to the link
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reqSeen_r <= 1'b0;
      ackTog_r  <= 1'b0;
      rdData_r  <= adrr_pkg::BYTE_ZERO;
    end
    else if (reqNew)
    begin
      reqSeen_r <= reqSync2_r;
      ackTog_r  <= ~ackTog_r;
      if (doRead)
        rdData_r <= readByte;
    end
  end

  // result registers follow each complete measurement
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      accelX_r <= adrr_pkg::AXIS_RESET;
      accelY_r <= adrr_pkg::AXIS_RESET;
      accelZ_r <= adrr_pkg::AXIS_RESET;
    end
    else if (measValid)
    begin
      accelX_r <= accelXResult;
      accelY_r <= accelYResult;
      accelZ_r <= accelZResult;
    end
  end

  // sticky flags and live watermark: a new event beats a clearing status read
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dataReady_r <= adrr_pkg::STATUS_RESET[adrr_pkg::ST_DATA_READY];
      activity_r  <= adrr_pkg::STATUS_RESET[adrr_pkg::ST_ACTIVITY];
      overrun_r   <= adrr_pkg::STATUS_RESET[adrr_pkg::ST_OVERRUN];
      watermark_r <= adrr_pkg::STATUS_RESET[adrr_pkg::ST_WATERMARK];
    end
    else
    begin
      dataReady_r <= measValid | (dataReady_r & ~clrStatus);
      activity_r  <= activityDetect | (activity_r & ~clrStatus);
      overrun_r   <= dropOld | (overrun_r & ~clrStatus);
      watermark_r <= (fillCount >= watermarkLevel);
    end
  end

  // sample queue
  adrr_fifo #(
    .WIDTH (adrr_pkg::ENTRY_W),
    .DEPTH (QUEUE_DEPTH),
    .LVL_W (LVL_W)
  ) u_queue (
    .clk      (clk),
    .rst      (rst),
    .inValid  (sampleValid),
    .inReady  (),
    .inData   (sampleWord),
    .outValid (fifoOutValid),
    .outReady (hostPop | dropOld),
    .outData  (fifoOutData),
    .level    (fifoLevel),
    .full     (fifoFull)
  );

  // queue acceptance is left open: a full queue always drains one entry,
  // either to the host or as a dropped oldest sample, in the cycle that
  // a new sample arrives, so every offered sample is taken

endmodule : adrr_readout

/* adrr_pkg.sv */
// constants shared by the accelerometer readout register block
package adrr_pkg;

  // register bus geometry
  localparam int ADDR_W   = 8;
  localparam int BYTE_W   = 8;

  // register offsets
  localparam logic [7:0] REG_REVISION  = 8'h03;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_FILL      = 8'h05;
  localparam logic [7:0] REG_TEMP_HIGH = 8'h06;
  localparam logic [7:0] REG_TEMP_LOW  = 8'h07;
  localparam logic [7:0] REG_X_UPPER   = 8'h08;
  localparam logic [7:0] REG_X_MIDDLE  = 8'h09;
  localparam logic [7:0] REG_X_LOWER   = 8'h0A;
  localparam logic [7:0] REG_Y_UPPER   = 8'h0B;
  localparam logic [7:0] REG_Y_MIDDLE  = 8'h0C;
  localparam logic [7:0] REG_Y_LOWER   = 8'h0D;
  localparam logic [7:0] REG_Z_UPPER   = 8'h0E;
  localparam logic [7:0] REG_Z_MIDDLE  = 8'h0F;
  localparam logic [7:0] REG_Z_LOWER   = 8'h10;
  localparam logic [7:0] REG_QUEUE     = 8'h11;

  // status field positions
  localparam int ST_DATA_READY = 0;
  localparam int ST_WATERMARK  = 1;
  localparam int ST_OVERRUN    = 2;
  localparam int ST_ACTIVITY   = 3;
  localparam int ST_NV_BUSY    = 4;

  // reset values
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [19:0] AXIS_RESET   = 20'h00000;
  localparam logic [23:0] ENTRY_RESET  = 24'h000000;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;

  // data widths and counts
  localparam int TEMP_W      = 12;
  localparam int AXIS_W      = 20;
  localparam int ENTRY_W     = 24;
  localparam int FILL_W      = 7;
  localparam int QUEUE_MAX   = 96;
  localparam logic [1:0] LAST_BYTE = 2'h2;

  // synchroniser depth for both crossings
  localparam int SYNC_STAGES = 2;

endpackage : adrr_pkg

/* adrr_fifo.sv */
// sample queue storage: flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module adrr_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16,
  parameter int LVL_W = $clog2(DEPTH + 1)
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // filling side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // draining side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData,
  // occupancy
  output logic [LVL_W-1:0]      level,
  output logic                  full
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];   // entry storage
  logic [PTR_W-1:0] wrPtr_r;         // next slot to fill
  logic [PTR_W-1:0] rdPtr_r;         // oldest entry
  logic [LVL_W-1:0] count_r;         // entries held
  logic             doPush;          // accepted write
  logic             doPop;           // accepted read

  // full may still accept when the same cycle drains one
  assign full     = (count_r == LVL_W'(DEPTH));
  assign inReady  = ~full | outReady;
  assign outValid = (count_r != '0);
  assign outData  = mem_r[rdPtr_r];
  assign level    = count_r;
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  // storage write, no reset needed on data
  always_ff @(posedge clk)
  begin
    if (doPush)
      mem_r[wrPtr_r] <= inData;
  end

  // pointers and occupancy
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (doPush)
        wrPtr_r <= (wrPtr_r == PTR_LAST) ? '0 : wrPtr_r + 1'b1;
      if (doPop)
        rdPtr_r <= (rdPtr_r == PTR_LAST) ? '0 : rdPtr_r + 1'b1;
      if (doPush & ~doPop)
        count_r <= count_r + 1'b1;
      else if (doPop & ~doPush)
        count_r <= count_r - 1'b1;
    end
  end

endmodule : adrr_fifo

/* adrr_readout_monitor.sv */
// link-side checker for the readout register block
`timescale 1ns/1ps
module adrr_readout_monitor #(
  parameter logic [7:0] REV_CODE = 8'h5A  // arbitrary revision value
) (
  // reset and link clock
  input wire logic       rst,
  input wire logic       linkClk,
  // link requests and answers
  input wire logic       linkStart,
  input wire logic [7:0] linkAddr,
  input wire logic       linkRead,
  input wire logic [7:0] linkData,
  input wire logic       linkDataValid,
  input wire logic       linkBusy
);
  default clocking cb @(posedge linkClk); endclocking
  default disable iff (rst);
  logic [7:0] ptr_r;      // burst pointer as the host sees it
  logic [7:0] ansAddr_r;  // address of the pending read
  logic       fixed_r;    // burst started at the queue port
  logic       ansInc_r;   // pending read reached by increment
  // follow the pointer through each accepted request
  always_ff @(posedge linkClk)
  begin
    if (rst)
    begin
      ptr_r     <= 8'h00;
      fixed_r   <= 1'b0;
      ansAddr_r <= 8'h00;
      ansInc_r  <= 1'b0;
    end
    else if (linkStart && !linkBusy)
    begin
      ptr_r   <= linkAddr;
      fixed_r <= (linkAddr == adrr_pkg::REG_QUEUE);
    end
    else if (linkRead && !linkBusy)
    begin
      ansAddr_r <= ptr_r;
      ansInc_r  <= !fixed_r;
      ptr_r     <= fixed_r ? ptr_r : ptr_r + 8'h01;
    end
  end
  property p_read_answer;
    linkRead && !linkStart && !linkBusy |=> linkBusy ##[1:4] linkDataValid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");
  property p_start_quiet;
    linkStart && !linkBusy |=> linkBusy ##[1:4] (!linkBusy && !linkDataValid);
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("start not acked");
  property p_valid_pulse;
    linkDataValid |=> !linkDataValid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
  property p_valid_ends_busy;
    linkDataValid |-> $fell(linkBusy);
  endproperty
  a_valid_ends_busy: assert property (p_valid_ends_busy) else $error("busy not ended");
  property p_data_hold;
    !linkDataValid |-> $stable(linkData);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved");
  property p_revision;
    linkDataValid && ansAddr_r == adrr_pkg::REG_REVISION |-> linkData == REV_CODE;
  endproperty
  a_revision: assert property (p_revision) else $error("revision wrong");
  property p_fill_range;
    linkDataValid && ansAddr_r == adrr_pkg::REG_FILL |-> linkData <= 8'h60;
  endproperty
  a_fill_range: assert property (p_fill_range) else $error("fill out of range");
  property p_temp_high;
    linkDataValid && ansAddr_r == adrr_pkg::REG_TEMP_HIGH |-> linkData[7:4] == 4'h0;
  endproperty
  a_temp_high: assert property (p_temp_high) else $error("temp high nibble");
  property p_axis_low;
    linkDataValid && ansAddr_r inside {8'h0A, 8'h0D, 8'h10} |-> linkData[3:0] == 4'h0;
  endproperty
  a_axis_low: assert property (p_axis_low) else $error("axis low nibble");
  property p_queue_inc;
    linkDataValid && ansInc_r && ansAddr_r == adrr_pkg::REG_QUEUE |-> linkData == 8'h00;
  endproperty
  a_queue_inc: assert property (p_queue_inc) else $error("queue by increment");
endmodule : adrr_readout_monitor

bind adrr_readout adrr_readout_monitor #(.REV_CODE(REV_CODE)) u_mon (.*);

/* adrr_host_model.sv */
// host controller model issuing link bursts
`timescale 1ns/1ps
module adrr_host_model (
  // link clock and answers
  input  wire logic       linkClk,
  input  wire logic       linkBusy,
  input  wire logic       linkDataValid,
  input  wire logic [7:0] linkData,
  // requests
  output logic            linkStart,
  output logic [7:0]      linkAddr,
  output logic            linkRead
);
  logic [7:0] got[$];  // bytes of the last burst
  // idle request lines
  initial
  begin
    linkStart = 1'b0;
    linkRead  = 1'b0;
    linkAddr  = 8'hA5;
  end
  // one request, driven for one link clock, then wait for the answer
  task automatic req(input logic s, input logic [7:0] a);
    int k;
    k = 0;
    linkStart <= s;
    linkRead  <= !s;
    linkAddr  <= a;
    @(posedge linkClk);
    linkStart <= 1'b0;
    linkRead  <= 1'b0;
    linkAddr  <= ~a;  // address no longer meaningful
    do @(posedge linkClk) k++; while (linkBusy && k < 8);
    if (!s && linkDataValid) got.push_back(linkData);
  endtask : req
  // start frame then n single-byte reads
  task automatic burst(input logic [7:0] a, input int n);
    got.delete();
    @(posedge linkClk);
    req(1'b1, a);
    repeat (n) req(1'b0, a);
  endtask : burst
endmodule : adrr_host_model

/* test_accel_data_readout_regs.sv */
// self-checking bench for the readout register block
`timescale 1ns/1ps
module test_accel_data_readout_regs;
  localparam logic [7:0] REV   = 8'h3C;  // arbitrary revision value
  localparam int         DEPTH = adrr_pkg::QUEUE_MAX;
  // design inputs and outputs
  logic        clk, rst, linkClk, measValid, sampleValid, activityDetect;
  logic        nonvolatileBusyFlag, linkStart, linkRead;
  logic [19:0] accelXResult, accelYResult, accelZResult;
  logic [11:0] temperature;
  logic [23:0] sampleWord;
  logic [6:0]  watermarkLevel;
  logic [7:0]  linkAddr, linkData;
  logic        linkDataValid, linkBusy;
  // reference model state and bench counters
  logic [19:0] mx, my, mz;
  logic [23:0] mq[$];
  logic [23:0] cur;
  logic        rdy, act, ovr;
  int          pos, n_fail, tests_run, cyc;
  adrr_readout #(.REV_CODE(REV), .QUEUE_DEPTH(DEPTH)) dut (.*);
  adrr_host_model host (.*);
  // clocks, unrelated in phase
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    linkClk = 1'b0;
    #37;
    forever #80 linkClk = ~linkClk;
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end
  // expected byte at address a, model side effects included
  function automatic logic [7:0] expByte(input logic [7:0] a, input logic fx);
    logic [59:0] r;
    logic [19:0] v;
    int          i;
    logic [7:0]  b;
    r = {mx, my, mz};
    i = int'(a) - 8;
    b = 8'h00;  // unmapped or queue by increment
    if (a == adrr_pkg::REG_REVISION) b = REV;
    else if (a == adrr_pkg::REG_STATUS)
    begin
      b = {3'h0, nonvolatileBusyFlag, act, ovr, mq.size() >= int'(watermarkLevel), rdy};
      {act, ovr, rdy} = 3'h0;
    end
    else if (a == adrr_pkg::REG_FILL) b = 8'(mq.size());
    else if (a == adrr_pkg::REG_TEMP_HIGH) b = {4'h0, temperature[11:8]};
    else if (a == adrr_pkg::REG_TEMP_LOW) b = temperature[7:0];
    else if (i >= 0 && i < 9)
    begin
      v = 20'(r >> (40 - 20 * (i / 3)));
      b = 8'({v, 4'h0} >> (16 - 8 * (i % 3)));
    end
    else if (fx && !(pos == 0 && mq.size() == 0))
    begin
      if (pos == 0) cur = mq.pop_front();
      b = 8'(cur >> (16 - 8 * pos));
      pos = (pos + 1) % 3;
    end
    return b;
  endfunction : expByte
  // byte comparison
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk8
  // burst through the host and compare every byte
  task automatic run(input logic [7:0] a, input int n);
    logic [7:0] p;
    logic       fx;
    host.burst(a, n);
    p = a;
    fx = (a == adrr_pkg::REG_QUEUE);
    chk8(8'(host.got.size()), 8'(n));
    foreach (host.got[i])
    begin
      chk8(host.got[i], expByte(p, fx));
      if (!fx) p++;
    end
  endtask : run
  // back-to-back queue pushes, oldest dropped when full
  task automatic push(input int n);
    logic [23:0] w;
    repeat (n)
    begin
      w = 24'($urandom);
      sampleValid <= 1'b1;
      sampleWord  <= w;
      mq.push_back(w);
      if (mq.size() > DEPTH)
      begin
        void'(mq.pop_front());
        ovr = 1'b1;
      end
      @(posedge clk);
    end
    sampleValid <= 1'b0;
    repeat (40) @(posedge clk);
  endtask : push
  // verdict
  task automatic results;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  // main sequence
  initial
  begin
    {rst, measValid, sampleValid, activityDetect, nonvolatileBusyFlag} = 5'h10;
    {accelXResult, accelYResult, accelZResult, sampleWord} = 84'h0;
    {mx, my, mz, rdy, act, ovr} = 63'h0;
    {pos, n_fail, tests_run, cyc} = 0;
    watermarkLevel = 7'h05;
    void'($urandom(21365));
    temperature = 12'($urandom);
    repeat (4) @(posedge linkClk);
    @(posedge clk) rst <= 1'b0;
    repeat (5) @(posedge linkClk);
    run(adrr_pkg::REG_REVISION, 16);
    $display("test reset map done");
    @(posedge clk);
    mx = 20'($urandom);
    my = 20'($urandom);
    mz = 20'($urandom);
    {accelXResult, accelYResult, accelZResult} <= {mx, my, mz};
    {measValid, activityDetect, nonvolatileBusyFlag} <= 3'h7;
    temperature <= 12'($urandom);  // held across both halves
    @(posedge clk);
    {measValid, activityDetect} <= 2'h0;
    {accelXResult, accelYResult, accelZResult} <= 60'($urandom);
    {rdy, act} = 2'h3;
    run(adrr_pkg::REG_STATUS, 14);
    run(adrr_pkg::REG_STATUS, 1);
    $display("test results done");
    @(posedge clk) nonvolatileBusyFlag <= 1'b0;
    push(5);
    run(adrr_pkg::REG_STATUS, 2);
    run(adrr_pkg::REG_QUEUE, 9);
    repeat (3) run(adrr_pkg::REG_QUEUE, 1);
    run(adrr_pkg::REG_QUEUE, 4);
    run(adrr_pkg::REG_STATUS, 2);
    $display("test queue done");
    @(posedge clk);
    push(DEPTH + 2);
    run(adrr_pkg::REG_STATUS, 2);
    run(adrr_pkg::REG_QUEUE, 3);
    run(adrr_pkg::REG_STATUS, 1);
    $display("test overrun done");
    results();
  end
endmodule : test_accel_data_readout_regs
